// ==== hdl/afc_pkg.sv ====
// constants, tables and carrier types for the automatic fan pwm controller
// assumes a single 200 MHz core clock and a byte-wide register port
//
// Behaviour
// R01: auto mode sets duty from assigned zone
// R02: any absolute-limit excursion forces all outputs 100%
// R03: at fan limit duty equals programmed minimum
// R04: duty linear to 100% at limit plus range
// R05: auto duty clamped to maximum pwm setting
// R06: absolute override beats clamp, released after hysteresis
// R07: override identical above or below limit plus range
// R08: start clear: defaults used, written values ignored
// R09: software programs parameters, then sets start
// R10: lock bit blocks parameter changes until power-off
// R11: software writes 00h to spin-up mode
// R12: range/frequency register fields, reset value C3
// R13: band bit picks low or high frequency range
// R14: frequency code table, default 0011
// R15: range code table, default 1100
// R16: locked range/frequency registers ignore writes
// R17: start clear: default frequency bits used
// R18: zone 4 register holds range and smoothing
// R19: below limit minus hysteresis: off or minimum
package afc_pkg;
    localparam int NUM_FANS = 3;
    localparam int NUM_ZONES = 4;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] RANGE_ADDR [NUM_ZONES] = '{8'h5F, 8'h60, 8'h61, 8'h3C};
    localparam logic [7:0] LIMIT_ADDR [NUM_ZONES] = '{8'h67, 8'h68, 8'h69, 8'h3B};
    localparam logic [7:0] ABS_ADDR [NUM_ZONES] = '{8'h6A, 8'h6B, 8'h6C, 8'h3D};
    localparam logic [7:0] MIN_ADDR [NUM_FANS] = '{8'h64, 8'h65, 8'h66};
    localparam logic [7:0] MAX_ADDR [NUM_FANS] = '{8'h38, 8'h39, 8'h3A};
    localparam logic [7:0] ZSEL_ADDR [NUM_FANS] = '{8'h5C, 8'h5D, 8'h5E};
    localparam logic [7:0] DUTY_ADDR [NUM_FANS] = '{8'h30, 8'h31, 8'h32};
    localparam logic [7:0] HYST_ADDR [2] = '{8'h6D, 8'h6E};
    localparam logic [7:0] MINOFF_ADDR = 8'h62;
    localparam logic [7:0] CTRL_ADDR = 8'h40;
    localparam logic [7:0] SPINUP_ADDR = 8'h75;

    // ------------------------------------------------------------
    // reset and default values
    // ------------------------------------------------------------
    localparam logic [7:0] RANGE_RESET = 8'hC3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SPINUP_RESET = 8'h01;
    localparam logic [7:0] LIMIT_DEFAULT = 8'h5A;
    localparam logic [7:0] ABS_DEFAULT = 8'h64;
    localparam logic [7:0] MIN_DEFAULT = 8'h80;
    localparam logic [7:0] MAX_DEFAULT = 8'hFF;
    localparam logic [7:0] HYST_DEFAULT = 8'h44;
    localparam logic [7:0] MINOFF_DEFAULT = 8'h00;
    localparam logic [7:0] ZSEL_DEFAULT [NUM_FANS] = '{8'h00, 8'h20, 8'h40};
    localparam logic [7:0] DUTY_FULL = 8'hFF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_START = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_READY = 2;
    localparam int CTRL_OVR = 3;
    localparam int CTRL_PECI = 4;
    localparam int CTRL_SAFE = 5;
    localparam int ZSEL_LSB = 5;
    localparam int MINOFF_LSB = 5;

    // ------------------------------------------------------------
    // range and frequency tables
    // ------------------------------------------------------------
    // ranges held in twelfths of a degree so every entry is whole
    localparam logic [11:0] RANGE_SCALE = 12'h00C;
    localparam logic [9:0] RANGE_X12 [16] = '{10'd24, 10'd30, 10'd40, 10'd48, 10'd60, 10'd80, 10'd96,
        10'd120, 10'd160, 10'd192, 10'd240, 10'd320, 10'd384, 10'd480, 10'd640, 10'd960};
    // 2^16 / RANGE_X12, avoids a divider in the duty path
    localparam logic [11:0] RANGE_RECIP [16] = '{12'd2731, 12'd2185, 12'd1638, 12'd1365, 12'd1092,
        12'd819, 12'd683, 12'd546, 12'd410, 12'd341, 12'd273, 12'd205, 12'd171, 12'd137, 12'd102, 12'd68};
    localparam int LOW_FREQ_HZ [8] = '{10, 15, 23, 30, 38, 47, 62, 94};
    localparam int HIGH_FREQ_BASE_HZ = 23000;
    localparam int HIGH_FREQ_STEP_HZ = 1000;
    localparam int PWM_STEPS = 256;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } afc_reg_req_type;

    // clock cycles per pwm step for band/frequency selection
    function automatic logic [23:0] afc_step_cycles(input logic [3:0] sel, input int clk_hz);
        int f;
        int c;
        f = sel[3] ? HIGH_FREQ_BASE_HZ + int'(sel[2:0]) * HIGH_FREQ_STEP_HZ : LOW_FREQ_HZ[sel[2:0]];
        c = clk_hz / (f * PWM_STEPS);
        if (c < 1)
        begin
            c = 1;
        end
        return c[23:0];
    endfunction
endpackage

// ==== hdl/afc_pwm_channel.sv ====
// one pwm output: step divider, 256-step phase, duty latched per period
// assumes step_i and duty_i are synchronous to clock_i
`timescale 1ns/1ps
module afc_pwm_channel
    import afc_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control
    input wire logic [23:0] step_i,
    input wire logic [7:0] duty_i,
    // output
    output logic pwm_o
);
    logic [23:0] div;
    logic [7:0] phase;
    logic [7:0] duty_q;
    wire tick = (div >= step_i - 24'h00_0001);

    // ------------------------------------------------------------
    // divider and phase
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div <= '0;
            phase <= '0;
            duty_q <= '0;
            pwm_o <= 1'b0;
        end
        else
        begin
            div <= tick ? '0 : div + 24'h00_0001;
            if (tick)
            begin
                phase <= phase + 8'h01;
            end
            // new duty only at period start, so a period is never cut short
            if (tick && phase == 8'hFF)
            begin
                duty_q <= duty_i;
            end
            pwm_o <= (duty_q == DUTY_FULL) || (phase < duty_q);
        end
    end
endmodule

// ==== hdl/afc_fan_ctrl.sv ====
// automatic fan pwm controller: registers, zone hysteresis, duty, pwm outputs
// assumes zone temperatures are unsigned whole degrees, synchronous to clock_i
`timescale 1ns/1ps
module afc_fan_ctrl
    import afc_pkg::*;
#(
    parameter int CLOCK_HZ = 200_000_000
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // register port
    input wire afc_reg_req_type reg_req_i,
    output logic [7:0] reg_rdata_o,
    // temperatures
    input wire logic [NUM_ZONES-1:0][7:0] zone_temp_i,
    // fans
    output logic [NUM_FANS-1:0] pwm_o
);
    logic rst_meta;
    logic rst_n;
    logic [7:0] range_reg [NUM_ZONES];
    logic [7:0] limit_reg [NUM_ZONES];
    logic [7:0] abs_reg [NUM_ZONES];
    logic [7:0] hyst_reg [2];
    logic [7:0] min_reg [NUM_FANS];
    logic [7:0] max_reg [NUM_FANS];
    logic [7:0] zsel_reg [NUM_FANS];
    logic [7:0] minoff_reg;
    logic [7:0] spinup_reg;
    logic start;
    logic lock;
    logic ready;
    logic ovr;
    logic peci;
    logic safe;
    logic [NUM_ZONES-1:0] abs_hot;
    logic [NUM_FANS-1:0] fan_on;
    logic [7:0] duty_q [NUM_FANS];
    logic [7:0] next_rdata;
    logic [3:0] eff_rng [NUM_ZONES];
    logic [7:0] eff_limit [NUM_ZONES];
    logic [7:0] eff_abs [NUM_ZONES];
    logic [7:0] eff_hyst [NUM_ZONES];
    logic [7:0] lo_abs [NUM_ZONES];
    logic [7:0] eff_max [NUM_FANS];
    logic [7:0] eff_min [NUM_FANS];
    logic [NUM_FANS-1:0] at_lim;
    logic [NUM_FANS-1:0] at_full;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    wire cfg_we = reg_req_i.wr && !lock; // [R10] [R16]
    wire ctrl_we = reg_req_i.wr && (reg_req_i.addr == CTRL_ADDR);
    wire force_full = ovr || (|abs_hot); // [R02] [R06]

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start <= 1'b0;
            lock <= 1'b0;
            ready <= 1'b0;
            ovr <= 1'b0;
            peci <= 1'b0;
            safe <= 1'b0;
        end
        else
        begin
            ready <= 1'b1;
            if (ctrl_we)
            begin
                start <= reg_req_i.data[CTRL_START]; // [R08]
                lock <= lock | reg_req_i.data[CTRL_LOCK]; // [R10]
                ovr <= reg_req_i.data[CTRL_OVR];
                safe <= reg_req_i.data[CTRL_SAFE];
                if (!lock)
                begin
                    peci <= reg_req_i.data[CTRL_PECI];
                end
            end
        end
    end

    // spin-up mode is only held; software is expected to clear it
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spinup_reg <= SPINUP_RESET; // [R11]
            minoff_reg <= MINOFF_DEFAULT;
            hyst_reg[0] <= HYST_DEFAULT;
            hyst_reg[1] <= HYST_DEFAULT;
        end
        else if (cfg_we)
        begin
            if (reg_req_i.addr == SPINUP_ADDR)
                spinup_reg <= reg_req_i.data;
            if (reg_req_i.addr == MINOFF_ADDR)
                minoff_reg <= reg_req_i.data;
            if (reg_req_i.addr == HYST_ADDR[0])
                hyst_reg[0] <= reg_req_i.data;
            if (reg_req_i.addr == HYST_ADDR[1])
                hyst_reg[1] <= reg_req_i.data;
        end
    end

    // ------------------------------------------------------------
    // per-zone registers and absolute-limit hysteresis
    // ------------------------------------------------------------
    for (genvar z = 0; z < NUM_ZONES; z++)
    begin : g_zone
        // zone 4 low nibble is smoothing enable and setting, stored only
        always_ff @(posedge clock_i or negedge rst_n)
        begin
            if (!rst_n)
            begin
                range_reg[z] <= RANGE_RESET; // [R12] [R18]
                limit_reg[z] <= LIMIT_DEFAULT;
                abs_reg[z] <= ABS_DEFAULT;
            end
            else if (cfg_we)
            begin
                if (reg_req_i.addr == RANGE_ADDR[z])
                    range_reg[z] <= reg_req_i.data; // [R16]
                if (reg_req_i.addr == LIMIT_ADDR[z])
                    limit_reg[z] <= reg_req_i.data;
                if (reg_req_i.addr == ABS_ADDR[z])
                    abs_reg[z] <= reg_req_i.data;
            end
        end

        wire [3:0] hyst_raw = (z % 2 == 0) ? hyst_reg[z / 2][7:4] : hyst_reg[z / 2][3:0];
        assign eff_rng[z] = start ? range_reg[z][7:4] : RANGE_RESET[7:4]; // [R08] [R15]
        assign eff_limit[z] = start ? limit_reg[z] : LIMIT_DEFAULT;
        assign eff_abs[z] = start ? abs_reg[z] : ABS_DEFAULT;
        assign eff_hyst[z] = start ? {4'h0, hyst_raw} : {4'h0, HYST_DEFAULT[7:4]};
        assign lo_abs[z] = (eff_abs[z] > eff_hyst[z]) ? eff_abs[z] - eff_hyst[z] : 8'h00;

        // independent of limit plus range, so placement of the limit does not matter
        always_ff @(posedge clock_i or negedge rst_n)
        begin
            if (!rst_n)
                abs_hot[z] <= 1'b0;
            else if (zone_temp_i[z] > eff_abs[z])
                abs_hot[z] <= 1'b1; // [R02] [R07]
            else if (zone_temp_i[z] < lo_abs[z])
                abs_hot[z] <= 1'b0; // [R06]
        end
    end

    // ------------------------------------------------------------
    // per-fan duty computation and pwm
    // ------------------------------------------------------------
    for (genvar f = 0; f < NUM_FANS; f++)
    begin : g_fan
        always_ff @(posedge clock_i or negedge rst_n)
        begin
            if (!rst_n)
            begin
                min_reg[f] <= MIN_DEFAULT;
                max_reg[f] <= MAX_DEFAULT;
                zsel_reg[f] <= ZSEL_DEFAULT[f];
            end
            else if (cfg_we)
            begin
                if (reg_req_i.addr == MIN_ADDR[f])
                    min_reg[f] <= reg_req_i.data;
                if (reg_req_i.addr == MAX_ADDR[f])
                    max_reg[f] <= reg_req_i.data;
                if (reg_req_i.addr == ZSEL_ADDR[f])
                    zsel_reg[f] <= reg_req_i.data;
            end
        end

        wire [7:0] zsel_eff = start ? zsel_reg[f] : ZSEL_DEFAULT[f];
        wire [1:0] zone = zsel_eff[ZSEL_LSB +: 2]; // [R01]
        wire [7:0] temp = zone_temp_i[zone];
        wire [7:0] lim = eff_limit[zone];
        wire [3:0] rcode = eff_rng[zone];
        wire [7:0] lo_lim = (lim > eff_hyst[zone]) ? lim - eff_hyst[zone] : 8'h00;
        wire keep_min = start ? minoff_reg[MINOFF_LSB + f] : MINOFF_DEFAULT[MINOFF_LSB + f];
        assign eff_min[f] = start ? min_reg[f] : MIN_DEFAULT;
        assign eff_max[f] = start ? max_reg[f] : MAX_DEFAULT;

        // linear slope: fraction of range covered, scaled to 2^16
        wire [7:0] delta = temp - lim;
        wire [11:0] d12 = {4'h0, delta} * RANGE_SCALE;
        wire [23:0] frac_full = {12'h000, d12} * {12'h000, RANGE_RECIP[rcode]};
        wire [15:0] frac = (frac_full[23:16] != 8'h00) ? 16'hFFFF : frac_full[15:0];
        wire [7:0] span = DUTY_FULL - eff_min[f];
        wire [23:0] lin_prod = {16'h0000, span} * {8'h00, frac};
        assign at_lim[f] = temp >= lim;
        assign at_full[f] = at_lim[f] && (d12 >= {2'b00, RANGE_X12[rcode]}); // [R04]
        wire [7:0] lin = at_full[f] ? DUTY_FULL : eff_min[f] + lin_prod[23:16]; // [R03] [R04]
        wire [7:0] below = (fan_on[f] || keep_min) ? eff_min[f] : 8'h00; // [R19]
        wire [7:0] auto_duty = at_lim[f] ? lin : below;
        wire [7:0] clamped = (auto_duty > eff_max[f]) ? eff_max[f] : auto_duty; // [R05]
        wire [7:0] next_duty = force_full ? DUTY_FULL : clamped; // [R02] [R06]

        always_ff @(posedge clock_i or negedge rst_n)
        begin
            if (!rst_n)
            begin
                fan_on[f] <= 1'b0;
                duty_q[f] <= 8'h00;
            end
            else
            begin
                if (at_lim[f])
                    fan_on[f] <= 1'b1;
                else if (temp < lo_lim)
                    fan_on[f] <= 1'b0; // [R19]
                duty_q[f] <= next_duty;
            end
        end

        // default frequency nibble while start is clear
        wire [3:0] freq_sel = start ? range_reg[f][3:0] : RANGE_RESET[3:0]; // [R17]
        wire [23:0] step = afc_step_cycles(freq_sel, CLOCK_HZ); // [R13] [R14]

        afc_pwm_channel u_chan (
            .clock_i(clock_i),
            .rst_n_i(rst_n),
            .step_i(step),
            .duty_i(duty_q[f]),
            .pwm_o(pwm_o[f])
        );
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        for (int i = 0; i < NUM_ZONES; i++)
        begin
            if (reg_req_i.addr == RANGE_ADDR[i])
                next_rdata = range_reg[i];
            if (reg_req_i.addr == LIMIT_ADDR[i])
                next_rdata = limit_reg[i];
            if (reg_req_i.addr == ABS_ADDR[i])
                next_rdata = abs_reg[i];
        end
        for (int i = 0; i < NUM_FANS; i++)
        begin
            if (reg_req_i.addr == MIN_ADDR[i])
                next_rdata = min_reg[i];
            if (reg_req_i.addr == MAX_ADDR[i])
                next_rdata = max_reg[i];
            if (reg_req_i.addr == ZSEL_ADDR[i])
                next_rdata = zsel_reg[i];
            if (reg_req_i.addr == DUTY_ADDR[i])
                next_rdata = duty_q[i];
        end
        if (reg_req_i.addr == HYST_ADDR[0])
            next_rdata = hyst_reg[0];
        if (reg_req_i.addr == HYST_ADDR[1])
            next_rdata = hyst_reg[1];
        if (reg_req_i.addr == MINOFF_ADDR)
            next_rdata = minoff_reg;
        if (reg_req_i.addr == SPINUP_ADDR)
            next_rdata = spinup_reg;
        if (reg_req_i.addr == CTRL_ADDR)
            next_rdata = {2'b00, safe, peci, ovr, ready, lock, start};
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_o <= 8'h00;
        else if (reg_req_i.rd)
            reg_rdata_o <= next_rdata;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n);

    AST_ABS_FORCE: assert property ((|abs_hot) |=> (duty_q[0] == DUTY_FULL && duty_q[1] == DUTY_FULL
        && duty_q[2] == DUTY_FULL)) // [R02]
        else $error("absolute excursion did not force full duty");
    AST_ABS_HOLD: assert property ((abs_hot[0] && zone_temp_i[0] >= lo_abs[0]) |=> abs_hot[0]) // [R06]
        else $error("absolute override released inside hysteresis");
    AST_AT_LIMIT: assert property ((zone_temp_i[0] == eff_limit[0] && !force_full && !start
        && eff_min[0] <= eff_max[0]) |=> duty_q[0] == $past(eff_min[0])) // [R03]
        else $error("duty at fan limit is not the minimum");
    AST_TOP_RANGE: assert property ((at_full[0] && !force_full) |=> duty_q[0] == $past(eff_max[0])) // [R04]
        else $error("duty not full at limit plus range");
    AST_CLAMP: assert property (!force_full |=> duty_q[0] <= $past(eff_max[0])) // [R05]
        else $error("automatic duty above maximum setting");
    AST_LOCK_STICKY: assert property (lock |=> lock) // [R10]
        else $error("lock bit cleared");
    AST_LOCK_RANGE: assert property ((lock && reg_req_i.wr && reg_req_i.addr == RANGE_ADDR[0])
        |=> $stable(range_reg[0])) // [R16]
        else $error("locked range register changed");
    AST_START_DEFAULT: assert property (!start |-> (g_fan[0].freq_sel == RANGE_RESET[3:0]
        && eff_rng[1] == RANGE_RESET[7:4])) // [R08] [R17]
        else $error("defaults not used while start is clear");
endmodule

// ==== bench/afc_fan_model.sv ====
// fan model: counts pwm high cycles in back-to-back 256-cycle windows
// assumes the bench clock is slow enough that every pwm step is one cycle
`timescale 1ns/1ps
module afc_fan_model
    import afc_pkg::*;
(
    // clock
    input wire logic clock_i,
    // pwm from the controller
    input wire logic [NUM_FANS-1:0] pwm_i,
    // high cycles seen in the last whole window
    output logic [NUM_FANS-1:0][8:0] high_cnt_o
);
    logic [7:0] win;
    logic [NUM_FANS-1:0][8:0] acc;

    initial
    begin
        win = 8'h00;
        acc = '0;
        high_cnt_o = '0;
    end

    // any window of one pwm period holds exactly the duty count
    always @(posedge clock_i)
    begin
        for (int f = 0; f < NUM_FANS; f++)
        begin
            if (win == 8'hFF)
            begin
                high_cnt_o[f] <= acc[f] + 9'(pwm_i[f]);
                acc[f] <= '0;
            end
            else
            begin
                acc[f] <= acc[f] + 9'(pwm_i[f]);
            end
        end
        win <= win + 8'h01;
    end
endmodule

// ==== bench/afc_fan_ctrl_tb.sv ====
// self-checking bench for the automatic fan pwm controller
// assumes a pwm period of 256 cycles from the reduced core clock rate
`timescale 1ns/1ps
module afc_fan_ctrl_tb;
    import afc_pkg::*;
    logic clock_i;
    logic rstn_i;
    afc_reg_req_type reg_req;
    logic [7:0] rdata;
    logic [NUM_ZONES-1:0][7:0] temps;
    logic [NUM_FANS-1:0] pwm;
    logic [NUM_FANS-1:0][8:0] cnt;
    logic [7:0] lfsr;
    int err_total;
    int checks_done;

    afc_fan_ctrl #(.CLOCK_HZ(2560)) dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(reg_req),
        .reg_rdata_o(rdata), .zone_temp_i(temps), .pwm_o(pwm));
    afc_fan_model fan_u (.clock_i(clock_i), .pwm_i(pwm), .high_cnt_o(cnt));

    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // full scale is constant high, so a whole period counts 256
    function automatic logic [8:0] duty_cnt(input logic [7:0] d);
        return (d == DUTY_FULL) ? 9'h100 : {1'b0, d};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_req <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
        @(negedge clock_i);
        reg_req <= '0;
    endtask

    task automatic chk_reg(input string n, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_i);
        reg_req <= '{addr: a, data: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clock_i);
        reg_req <= '0;
        checks_done++;
        if (rdata !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", n, exp, rdata);
        end
    endtask

    // duty path may differ from the exact line by one step
    task automatic chk_duty(input int f, input logic [7:0] d);
        logic [8:0] e;
        e = duty_cnt(d);
        checks_done++;
        if (cnt[f] !== e && cnt[f] !== e + 9'h001 && cnt[f] !== e - 9'h001)
        begin
            err_total++;
            $display("Error fan%0d duty expected %h seen %h", f + 1, e, cnt[f]);
        end
    endtask

    task automatic settle();
        repeat (800) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    task automatic set_t(input int z, input logic [7:0] t);
        @(negedge clock_i);
        temps[z] <= t;
        settle();
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #(5 * 60000);
        err_total++;
        end_sim();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        err_total = 0;
        checks_done = 0;
        rstn_i = 1'b0;
        reg_req = '0;
        temps = '0;
        lfsr = 8'h38;
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clock_i);

        for (int i = 0; i < NUM_ZONES; i++)
            chk_reg("range reset", RANGE_ADDR[i], RANGE_RESET);
        chk_reg("control reset", CTRL_ADDR, 8'h04);
        chk_reg("spinup reset", SPINUP_ADDR, SPINUP_RESET);
        chk_reg("unmapped", 8'h00, 8'h00);
        for (int i = 1; i < NUM_ZONES; i++)
        begin
            lfsr = next_rand(lfsr);
            wr(RANGE_ADDR[i], lfsr);
            chk_reg("range rw", RANGE_ADDR[i], lfsr);
        end
        $display("test reset_regs done");

        // written limit must be ignored while start is clear
        wr(LIMIT_ADDR[0], 8'h10);
        lfsr = next_rand(lfsr);
        set_t(0, lfsr & 8'h3F);
        chk_duty(0, 8'h00);
        set_t(0, LIMIT_DEFAULT);
        chk_duty(0, MIN_DEFAULT);
        set_t(3, 8'h65);
        for (int f = 0; f < NUM_FANS; f++)
            chk_duty(f, DUTY_FULL);
        set_t(3, 8'h61);
        chk_duty(0, DUTY_FULL);
        set_t(3, 8'h5F);
        chk_duty(0, MIN_DEFAULT);
        chk_duty(1, 8'h00);
        set_t(3, 8'h00);
        $display("test defaults done");

        // software order: parameters first, start last
        wr(LIMIT_ADDR[0], 8'h32);
        wr(RANGE_ADDR[0], 8'h63);
        wr(MIN_ADDR[0], 8'h80);
        wr(ABS_ADDR[0], 8'h60);
        wr(HYST_ADDR[0], 8'h50);
        wr(ZSEL_ADDR[1], 8'h00);
        wr(SPINUP_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h01);
        set_t(0, 8'h32);
        chk_duty(0, 8'h80);
        chk_duty(1, MIN_DEFAULT);
        set_t(0, 8'h36);
        chk_duty(0, 8'hC0);
        set_t(0, 8'h3A);
        chk_duty(0, DUTY_FULL);
        set_t(0, 8'h45);
        chk_duty(0, DUTY_FULL);
        wr(MAX_ADDR[0], 8'hA0);
        set_t(0, 8'h3A);
        chk_duty(0, 8'hA0);
        set_t(0, 8'h61);
        chk_duty(0, DUTY_FULL);
        set_t(0, 8'h5C);
        chk_duty(0, DUTY_FULL);
        set_t(0, 8'h5A);
        chk_duty(0, 8'hA0);
        $display("test programmed done");

        // absolute limit now below limit plus range
        wr(ABS_ADDR[0], 8'h34);
        set_t(0, 8'h35);
        chk_duty(0, DUTY_FULL);
        set_t(0, 8'h20);
        chk_duty(0, 8'h00);
        wr(MINOFF_ADDR, 8'h20);
        settle();
        chk_duty(0, 8'h80);
        $display("test override_minoff done");

        wr(CTRL_ADDR, 8'h03);
        lfsr = next_rand(lfsr);
        wr(RANGE_ADDR[0], lfsr);
        chk_reg("locked range", RANGE_ADDR[0], 8'h63);
        wr(CTRL_ADDR, 8'h00);
        chk_reg("lock sticky", CTRL_ADDR, 8'h06);
        // override still works with the lock set
        wr(CTRL_ADDR, 8'h09);
        settle();
        for (int f = 0; f < NUM_FANS; f++)
            chk_duty(f, DUTY_FULL);
        $display("test lock done");
        end_sim();
    end
endmodule
